// ---- logic/uhe_pkg.sv ----
package uhe_pkg;
    // Timing
    localparam int CLK_MHZ = 50;
    localparam int CLK_HZ = 50_000_000;
    localparam int FS_BIT_HZ = 12_000_000;
    localparam int FRAME_US = 1000;
    localparam int FRAME_CYC = FRAME_US * CLK_MHZ;
    localparam int EOF2_BIT_TIMES = 10;
    localparam int EOF2_CYC = EOF2_BIT_TIMES * CLK_HZ / FS_BIT_HZ;
    localparam int FT_W = 17;

    // Register byte offsets
    localparam logic [7:0] OFF_FRAME = 8'h00;
    localparam logic [7:0] OFF_ADDR = 8'h04;
    localparam logic [7:0] OFF_EP0_IRQ = 8'h08;
    localparam logic [7:0] OFF_EP0_CTRL = 8'h0c;
    localparam logic [7:0] OFF_EP1 = 8'h10;

    // Frame flag indices and enable field
    localparam int FL_LOCK = 0;
    localparam int FL_SOF = 1;
    localparam int FL_EOF2 = 2;
    localparam int FL_EOP = 3;
    localparam int FL_TRAN = 4;
    localparam int FL_W = 5;
    localparam int FIE_LSB = 8;
    localparam int FIE_W = 4;

    // Byte fields
    localparam int EN_BIT = 7;
    localparam int HADDR_W = 7;
    localparam int TXF_BIT = 7;
    localparam int RXF_BIT = 6;
    localparam int TXIE_BIT = 3;
    localparam int RXIE_BIT = 2;
    localparam int TXCLR_BIT = 1;
    localparam int RXCLR_BIT = 0;
    localparam int TOG_BIT = 7;
    localparam int STALL_BIT = 6;
    localparam int TXE_BIT = 5;
    localparam int RXE_BIT = 4;
    localparam int CNT_W = 4;
    localparam int EP1_FORCE_STALL_BIT = 7;
    localparam int EP1_CHANGE_PENDING_BIT = 6;
    localparam int MAP_W = 6;

    localparam logic [3:0] EP0 = 4'h0;
    localparam logic [3:0] EP1 = 4'h1;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef enum logic [1:0] {PID_IN, PID_OUT, PID_SETUP} uhe_pid_type;
    typedef enum logic [1:0] {RESP_ACK, RESP_NAK, RESP_STALL, RESP_DATA} uhe_kind_type;

    typedef struct packed {
        logic valid;
        uhe_pid_type pid;
        logic [HADDR_W-1:0] addr;
        logic [3:0] ep;
    } uhe_token_type;

    typedef struct packed {
        logic sof;
        logic eop;
        logic activity;
        logic host_ack;
        logic rx_pkt_ok;
    } uhe_event_type;

    typedef struct packed {
        logic valid;
        uhe_kind_type kind;
        logic data1;
        logic [CNT_W-1:0] len;
        logic [MAP_W-1:0] bitmap;
    } uhe_resp_type;
endpackage : uhe_pkg

// ---- logic/uhe_top.sv ----
// Hub endpoint control, frame flags and AXI4-Lite register file
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module uhe_top #(
    parameter int FRAME_CYCLES = uhe_pkg::FRAME_CYC
) (
    // Clock and resets
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic por_n,
    // AXI4-Lite write
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // Link side
    input wire uhe_pkg::uhe_token_type tok,
    input wire uhe_pkg::uhe_event_type ev,
    output uhe_pkg::uhe_resp_type resp_r,
    // Power and interrupt
    output logic regulator_output_r,
    output logic xcvr_en_r,
    output logic usb_irq_r
);
    typedef enum logic [1:0] {ST_IDLE, ST_OUT_DATA, ST_IN_ACK} uhe_state_type;

    localparam int FT_EOF2 = FRAME_CYCLES - uhe_pkg::EOF2_CYC;
    localparam int FT_LOST = FRAME_CYCLES + uhe_pkg::EOF2_CYC;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // AXI state
    logic aw_held_r, w_held_r, aw_rdy_r, w_rdy_r, bvalid_r, ar_rdy_r, rvalid_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r, rdata_r, rd_word;
    logic [3:0] wstrb_r;
    logic [1:0] bresp_r, rresp_r;
    logic rd_ok, wr_ok;

    // Register state
    logic [uhe_pkg::FL_W-1:0] fflags_r, fflags_nxt, fset, fclr;
    logic [uhe_pkg::FIE_W-1:0] fie_r;
    logic mod_en_r;
    logic [uhe_pkg::HADDR_W-1:0] haddr_r;
    logic tx_done_r, rx_done_r, tx_ie_r, rx_ie_r;
    logic toggle_r, ep0_force_stall_r, txe_r, rxe_r;
    logic [uhe_pkg::CNT_W-1:0] cnt_r;
    logic ep1_force_stall_r, ep1_change_pending_r;
    logic [uhe_pkg::MAP_W-1:0] bitmap_r;

    // Frame timer and endpoint machine
    logic [uhe_pkg::FT_W-1:0] ft_cnt_r;
    logic ft_run_r;
    uhe_state_type st_r, st_nxt;
    uhe_pkg::uhe_resp_type resp_nxt;
    logic setup_evt, tx_set, rx_set;

    wire rst = !aresetn || !por_n;
    wire link_on = mod_en_r;
    wire aw_fire = s_awvalid && aw_rdy_r;
    wire w_fire = s_wvalid && w_rdy_r;
    wire do_wr = aw_held_r && w_held_r && !bvalid_r;
    wire ar_fire = s_arvalid && ar_rdy_r;
    wire aw_held_nxt = aw_fire || (aw_held_r && !do_wr);
    wire w_held_nxt = w_fire || (w_held_r && !do_wr);
    wire rvalid_nxt = ar_fire || (rvalid_r && !s_rready);
    wire b0 = wstrb_r[0];
    wire b1 = wstrb_r[1];
    wire wr_frame = do_wr && hit(awaddr_r, uhe_pkg::OFF_FRAME);
    wire wr_addr = do_wr && hit(awaddr_r, uhe_pkg::OFF_ADDR) && b0;
    wire wr_irq = do_wr && hit(awaddr_r, uhe_pkg::OFF_EP0_IRQ) && b0;
    wire wr_ctrl = do_wr && hit(awaddr_r, uhe_pkg::OFF_EP0_CTRL) && b0;
    wire wr_ep1 = do_wr && hit(awaddr_r, uhe_pkg::OFF_EP1) && b0;

    assign s_awready = aw_rdy_r;
    assign s_wready = w_rdy_r;
    assign s_bvalid = bvalid_r;
    assign s_bresp = bresp_r;
    assign s_arready = ar_rdy_r;
    assign s_rvalid = rvalid_r;
    assign s_rdata = rdata_r;
    assign s_rresp = rresp_r;

    // Write channel: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (rst) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_rdy_r <= 1'b0;
            w_rdy_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= uhe_pkg::AXI_OKAY;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else begin
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            aw_rdy_r <= !aw_held_nxt;
            w_rdy_r <= !w_held_nxt;
            if (aw_fire) begin
                awaddr_r <= s_awaddr;
            end
            if (w_fire) begin
                wdata_r <= s_wdata;
                wstrb_r <= s_wstrb;
            end
            if (do_wr) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_ok ? uhe_pkg::AXI_OKAY : uhe_pkg::AXI_SLVERR;
            end else if (s_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    assign wr_ok = hit(awaddr_r, uhe_pkg::OFF_FRAME) || hit(awaddr_r, uhe_pkg::OFF_ADDR)
        || hit(awaddr_r, uhe_pkg::OFF_EP0_IRQ) || hit(awaddr_r, uhe_pkg::OFF_EP0_CTRL)
        || hit(awaddr_r, uhe_pkg::OFF_EP1);

    // Read decode; clear strobes read back as zero
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b1;
        if (hit(s_araddr, uhe_pkg::OFF_FRAME)) begin
            rd_word = {20'h00000, fie_r, 3'h0, fflags_r};
        end else if (hit(s_araddr, uhe_pkg::OFF_ADDR)) begin
            rd_word = {24'h000000, mod_en_r, haddr_r};
        end else if (hit(s_araddr, uhe_pkg::OFF_EP0_IRQ)) begin
            rd_word = {24'h000000, tx_done_r, rx_done_r, 2'h0, tx_ie_r, rx_ie_r, 2'h0};
        end else if (hit(s_araddr, uhe_pkg::OFF_EP0_CTRL)) begin
            rd_word = {24'h000000, toggle_r, ep0_force_stall_r, txe_r, rxe_r, cnt_r};
        end else if (hit(s_araddr, uhe_pkg::OFF_EP1)) begin
            rd_word = {24'h000000, ep1_force_stall_r, ep1_change_pending_r, bitmap_r};
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (rst) begin
            ar_rdy_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= uhe_pkg::AXI_OKAY;
        end else begin
            ar_rdy_r <= !rvalid_nxt;
            rvalid_r <= rvalid_nxt;
            if (ar_fire) begin
                rdata_r <= rd_word;
                rresp_r <= rd_ok ? uhe_pkg::AXI_OKAY : uhe_pkg::AXI_SLVERR;
            end
        end
    end

    // Frame timer; a missed SOF stops it so lock must be re-earned
    wire sof_in = link_on && ev.sof;
    wire eof2_hit = ft_run_r && (ft_cnt_r == uhe_pkg::FT_W'(FT_EOF2));
    wire lock_hit = sof_in && ft_run_r && (ft_cnt_r >= uhe_pkg::FT_W'(FT_EOF2));

    always_ff @(posedge aclk) begin
        if (rst) begin
            ft_cnt_r <= '0;
            ft_run_r <= 1'b0;
        end else if (sof_in) begin
            ft_cnt_r <= '0;
            ft_run_r <= 1'b1;
        end else if (ft_run_r) begin
            ft_run_r <= (ft_cnt_r != uhe_pkg::FT_W'(FT_LOST));
            ft_cnt_r <= ft_cnt_r + uhe_pkg::FT_W'(1);
        end
    end

    // Hardware set beats a same-cycle clear strobe
    assign fset[uhe_pkg::FL_LOCK] = lock_hit;
    assign fset[uhe_pkg::FL_SOF] = sof_in;
    assign fset[uhe_pkg::FL_EOF2] = eof2_hit;
    assign fset[uhe_pkg::FL_EOP] = link_on && ev.eop;
    assign fset[uhe_pkg::FL_TRAN] = link_on && ev.activity;
    assign fclr = (wr_frame && b0) ? wdata_r[uhe_pkg::FL_W-1:0] : '0;
    assign fflags_nxt = fset | (fflags_r & ~fclr);

    // Token decisions
    wire tok_hit = link_on && tok.valid && (tok.addr == haddr_r);
    wire is_ep0 = (tok.ep == uhe_pkg::EP0);
    wire is_ep1 = (tok.ep == uhe_pkg::EP1);

    always_comb begin
        resp_nxt = '0;
        st_nxt = st_r;
        setup_evt = 1'b0;
        tx_set = 1'b0;
        rx_set = 1'b0;
        if (!link_on) begin
            st_nxt = ST_IDLE;
        end else if (tok_hit) begin
            st_nxt = ST_IDLE;
            if (is_ep0) begin
                case (tok.pid)
                    uhe_pkg::PID_SETUP: begin
                        setup_evt = 1'b1;
                        st_nxt = ST_OUT_DATA;
                    end
                    uhe_pkg::PID_OUT: begin
                        resp_nxt.valid = ep0_force_stall_r || !rxe_r || rx_done_r;
                        if (ep0_force_stall_r) begin
                            resp_nxt.kind = uhe_pkg::RESP_STALL;
                        end else if (!rxe_r || rx_done_r) begin
                            resp_nxt.kind = uhe_pkg::RESP_NAK;
                        end else begin
                            st_nxt = ST_OUT_DATA;
                        end
                    end
                    default: begin
                        resp_nxt.valid = 1'b1;
                        if (ep0_force_stall_r) begin
                            resp_nxt.kind = uhe_pkg::RESP_STALL;
                        end else if (!txe_r || tx_done_r) begin
                            resp_nxt.kind = uhe_pkg::RESP_NAK;
                        end else begin
                            resp_nxt.kind = uhe_pkg::RESP_DATA;
                            resp_nxt.data1 = toggle_r;
                            resp_nxt.len = cnt_r;
                            st_nxt = ST_IN_ACK;
                        end
                    end
                endcase
            end else if (is_ep1 && tok.pid == uhe_pkg::PID_IN) begin
                resp_nxt.valid = 1'b1;
                if (ep1_force_stall_r) begin
                    resp_nxt.kind = uhe_pkg::RESP_STALL;
                end else if (!ep1_change_pending_r) begin
                    resp_nxt.kind = uhe_pkg::RESP_NAK;
                end else begin
                    resp_nxt.kind = uhe_pkg::RESP_DATA;
                    resp_nxt.bitmap = bitmap_r;
                end
            end
        end else begin
            case (st_r)
                ST_OUT_DATA: begin
                    if (ev.rx_pkt_ok) begin
                        resp_nxt.valid = 1'b1;
                        resp_nxt.kind = uhe_pkg::RESP_ACK;
                        rx_set = 1'b1;
                        st_nxt = ST_IDLE;
                    end
                end
                ST_IN_ACK: begin
                    if (ev.host_ack) begin
                        tx_set = 1'b1;
                        st_nxt = ST_IDLE;
                    end
                end
                default: st_nxt = ST_IDLE;
            endcase
        end
    end

    wire irq_nxt = |(fflags_r[uhe_pkg::FL_W-1:1] & fie_r)
        || (tx_done_r && tx_ie_r) || (rx_done_r && rx_ie_r);

    // Enable survives bus resets; only power-on drops it
    always_ff @(posedge aclk) begin
        if (!por_n) begin
            mod_en_r <= 1'b0;
        end else if (wr_addr && wdata_r[uhe_pkg::EN_BIT]) begin
            mod_en_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (rst) begin
            st_r <= ST_IDLE;
            resp_r <= '0;
            fflags_r <= '0;
            fie_r <= '0;
            haddr_r <= '0;
            tx_done_r <= 1'b0;
            rx_done_r <= 1'b0;
            tx_ie_r <= 1'b0;
            rx_ie_r <= 1'b0;
            toggle_r <= 1'b0;
            ep0_force_stall_r <= 1'b0;
            txe_r <= 1'b0;
            rxe_r <= 1'b0;
            cnt_r <= '0;
            ep1_force_stall_r <= 1'b0;
            ep1_change_pending_r <= 1'b0;
            bitmap_r <= '0;
            usb_irq_r <= 1'b0;
            regulator_output_r <= 1'b0;
            xcvr_en_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            resp_r <= resp_nxt;
            fflags_r <= fflags_nxt;
            usb_irq_r <= irq_nxt;
            regulator_output_r <= mod_en_r;
            xcvr_en_r <= mod_en_r;
            tx_done_r <= tx_set || (tx_done_r && !(wr_irq && wdata_r[uhe_pkg::TXCLR_BIT]));
            rx_done_r <= rx_set || (rx_done_r && !(wr_irq && wdata_r[uhe_pkg::RXCLR_BIT]));
            if (wr_frame && b1) begin
                fie_r <= wdata_r[uhe_pkg::FIE_LSB +: uhe_pkg::FIE_W];
            end
            if (wr_addr) begin
                haddr_r <= wdata_r[uhe_pkg::HADDR_W-1:0];
            end
            if (wr_irq) begin
                tx_ie_r <= wdata_r[uhe_pkg::TXIE_BIT];
                rx_ie_r <= wdata_r[uhe_pkg::RXIE_BIT];
            end
            if (wr_ctrl) begin
                toggle_r <= wdata_r[uhe_pkg::TOG_BIT];
                txe_r <= wdata_r[uhe_pkg::TXE_BIT];
                rxe_r <= wdata_r[uhe_pkg::RXE_BIT];
                cnt_r <= wdata_r[uhe_pkg::CNT_W-1:0];
            end
            // SETUP clear wins over a same-cycle software write
            if (setup_evt) begin
                ep0_force_stall_r <= 1'b0;
            end else if (wr_ctrl) begin
                ep0_force_stall_r <= wdata_r[uhe_pkg::STALL_BIT];
            end
            if (wr_ep1) begin
                ep1_force_stall_r <= wdata_r[uhe_pkg::EP1_FORCE_STALL_BIT];
                ep1_change_pending_r <= wdata_r[uhe_pkg::EP1_CHANGE_PENDING_BIT];
                bitmap_r <= wdata_r[uhe_pkg::MAP_W-1:0];
            end
        end
    end

    property p_lock_clear;
        @(posedge aclk) disable iff (rst)
        (wr_frame && b0 && wdata_r[uhe_pkg::FL_LOCK] && !lock_hit) |=> !fflags_r[uhe_pkg::FL_LOCK];
    endproperty
    a_lock_clear: assert property (p_lock_clear) else $error("lock flag not cleared");

    property p_sof_flag_held;
        @(posedge aclk) disable iff (rst)
        (fflags_r[uhe_pkg::FL_SOF] && !(wr_frame && b0)) |=> fflags_r[uhe_pkg::FL_SOF];
    endproperty
    a_sof_flag_held: assert property (p_sof_flag_held) else $error("sof flag lost");

    property p_disabled_quiet;
        @(posedge aclk) disable iff (rst)
        !mod_en_r |=> (!resp_r.valid && !regulator_output_r && !xcvr_en_r);
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled but active");

    property p_enable_sticky;
        @(posedge aclk) disable iff (!por_n)
        mod_en_r |=> mod_en_r;
    endproperty
    a_enable_sticky: assert property (p_enable_sticky) else $error("enable dropped");

    property p_in_nak;
        @(posedge aclk) disable iff (rst)
        (tok_hit && is_ep0 && tok.pid == uhe_pkg::PID_IN && !ep0_force_stall_r && (!txe_r || tx_done_r))
        |=> (resp_r.valid && resp_r.kind == uhe_pkg::RESP_NAK);
    endproperty
    a_in_nak: assert property (p_in_nak) else $error("IN not NAKed");

    property p_out_nak;
        @(posedge aclk) disable iff (rst)
        (tok_hit && is_ep0 && tok.pid == uhe_pkg::PID_OUT && !ep0_force_stall_r && (!rxe_r || rx_done_r))
        |=> (resp_r.valid && resp_r.kind == uhe_pkg::RESP_NAK);
    endproperty
    a_out_nak: assert property (p_out_nak) else $error("OUT not NAKed");

    property p_rx_ack;
        @(posedge aclk) disable iff (rst)
        (st_r == ST_OUT_DATA && link_on && !tok_hit && ev.rx_pkt_ok)
        |=> (rx_done_r && resp_r.kind == uhe_pkg::RESP_ACK);
    endproperty
    a_rx_ack: assert property (p_rx_ack) else $error("rx done missing");

    property p_in_data;
        @(posedge aclk) disable iff (rst)
        (tok_hit && is_ep0 && tok.pid == uhe_pkg::PID_IN && !ep0_force_stall_r && txe_r && !tx_done_r)
        |=> (resp_r.kind == uhe_pkg::RESP_DATA && resp_r.data1 == $past(toggle_r)
             && resp_r.len == $past(cnt_r));
    endproperty
    a_in_data: assert property (p_in_data) else $error("wrong IN data");

    property p_setup_unstall;
        @(posedge aclk) disable iff (rst)
        (tok_hit && is_ep0 && tok.pid == uhe_pkg::PID_SETUP) |=> !ep0_force_stall_r;
    endproperty
    a_setup_unstall: assert property (p_setup_unstall) else $error("stall kept");

    property p_ep1_stall;
        @(posedge aclk) disable iff (rst)
        (tok_hit && is_ep1 && tok.pid == uhe_pkg::PID_IN && ep1_force_stall_r)
        |=> (resp_r.valid && resp_r.kind == uhe_pkg::RESP_STALL);
    endproperty
    a_ep1_stall: assert property (p_ep1_stall) else $error("ep1 not stalled");

    property p_eof2;
        @(posedge aclk) disable iff (rst)
        eof2_hit |=> fflags_r[uhe_pkg::FL_EOF2];
    endproperty
    a_eof2: assert property (p_eof2) else $error("eof2 flag missing");

    property p_irq;
        @(posedge aclk) disable iff (rst)
        ((tx_done_r && tx_ie_r) || (rx_done_r && rx_ie_r)) |=> usb_irq_r;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not raised");
endmodule : uhe_top

// ---- testbench/uhe_host_model.sv ----
// Upstream host model: token and link event source
`timescale 1ns/1ps
module uhe_host_model (
    // Clock
    input wire logic aclk,
    // Link
    output uhe_pkg::uhe_token_type tok,
    output uhe_pkg::uhe_event_type ev
);
    initial begin
        tok = '0;
        ev = '0;
    end

    task automatic token(input uhe_pkg::uhe_pid_type p, input logic [6:0] a,
                         input logic [3:0] e);
        @(posedge aclk);
        tok <= {1'b1, p, a, e};
        @(posedge aclk);
        // Stale fields scrambled so nothing leans on the last token
        tok <= {1'b0, ~p, ~a, ~e};
    endtask : token

    task automatic event_pulse(input logic [4:0] m);
        @(posedge aclk);
        ev <= m;
        @(posedge aclk);
        ev <= '0;
    endtask : event_pulse
endmodule : uhe_host_model

// ---- testbench/tb.sv ----
// Self-checking bench for the hub endpoint control block
`timescale 1ns/1ps
module tb;
    logic aclk, aresetn, por_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq, reg_on, xcvr, clr_got;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp, br_q;
    uhe_pkg::uhe_token_type tok;
    uhe_pkg::uhe_event_type ev;
    uhe_pkg::uhe_resp_type resp, got;
    int error_cnt = 0;
    int compares = 0;
    // Expected answers and masks: valid and kind, plus toggle/length or bitmap
    localparam uhe_pkg::uhe_resp_type km = 14'h3800;
    localparam uhe_pkg::uhe_resp_type dm = 14'h3fc0;
    localparam uhe_pkg::uhe_resp_type bm = 14'h383f;
    localparam uhe_pkg::uhe_resp_type ack = {1'b1, uhe_pkg::RESP_ACK, 11'h0};
    localparam uhe_pkg::uhe_resp_type nak = {1'b1, uhe_pkg::RESP_NAK, 11'h0};
    localparam uhe_pkg::uhe_resp_type stl = {1'b1, uhe_pkg::RESP_STALL, 11'h0};

    uhe_top #(.FRAME_CYCLES(200)) i_uhe_top (.aclk(aclk), .aresetn(aresetn), .por_n(por_n),
        .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
        .s_wstrb(4'hf), .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp),
        .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
        .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
        .s_rready(rready), .tok(tok), .ev(ev), .resp_r(resp),
        .regulator_output_r(reg_on), .xcvr_en_r(xcvr), .usb_irq_r(irq));
    uhe_host_model i_uhe_host_model (.aclk(aclk), .tok(tok), .ev(ev));

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // Single owner of got; tchk only asks for a clear
    always @(posedge aclk) begin
        if (resp.valid === 1'b1) got <= resp;
        else if (clr_got) got <= '0;
    end

    task automatic results();
        if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results

    task automatic chk(input logic [33:0] g, e);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        // Ready stays up so a following call never drives it twice in one step
        br_q = bresp;
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        chk({rresp, rdata}, {r, e});
    endtask : rchk

    // Token to hub address 5, optional follow-up event, then the captured answer
    task automatic tchk(input uhe_pkg::uhe_pid_type p, input logic [3:0] ep,
                        input logic [4:0] evm, input uhe_pkg::uhe_resp_type m, x);
        clr_got <= 1'b1;
        i_uhe_host_model.token(p, 7'h05, ep);
        clr_got <= 1'b0;
        if (evm != 5'h0) i_uhe_host_model.event_pulse(evm);
        repeat (2) @(posedge aclk);
        chk(got & m, x);
    endtask : tchk

    initial begin
        {aresetn, por_n, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        clr_got = 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        por_n <= 1'b1;
        @(posedge aclk);
        wr(8'h04, 32'h05);
        tchk(uhe_pkg::PID_IN, 4'h0, 5'h0, km, '0);
        chk({reg_on, xcvr}, 2'b00);
        wr(8'h04, 32'h85);
        rchk(8'h04, 32'h85);
        wr(8'h04, 32'h05);
        rchk(8'h04, 32'h85);
        chk({reg_on, xcvr}, 2'b11);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i <= 16; i += 4) rchk(i[7:0], i == 4 ? 32'h80 : 32'h0);
        wr(8'h04, 32'h05);
        tchk(uhe_pkg::PID_IN, 4'h0, 5'h0, km, nak);
        wr(8'h0c, 32'ha9);
        tchk(uhe_pkg::PID_IN, 4'h0, 5'h02, dm, {1'b1, uhe_pkg::RESP_DATA, 5'h19, 6'h0});
        rchk(8'h08, 32'h80);
        tchk(uhe_pkg::PID_IN, 4'h0, 5'h0, km, nak);
        wr(8'h08, 32'h08);
        rchk(8'h08, 32'h88);
        chk(irq, 1'b1);
        wr(8'h08, 32'h0a);
        rchk(8'h08, 32'h08);
        chk(irq, 1'b0);
        wr(8'h0c, 32'h23);
        tchk(uhe_pkg::PID_IN, 4'h0, 5'h0, dm, {1'b1, uhe_pkg::RESP_DATA, 5'h03, 6'h0});
        tchk(uhe_pkg::PID_OUT, 4'h0, 5'h0, km, nak);
        wr(8'h0c, 32'h10);
        wr(8'h08, 32'h04);
        tchk(uhe_pkg::PID_OUT, 4'h0, 5'h01, km, ack);
        rchk(8'h08, 32'h44);
        chk(irq, 1'b1);
        tchk(uhe_pkg::PID_OUT, 4'h0, 5'h0, km, nak);
        wr(8'h08, 32'h05);
        rchk(8'h08, 32'h04);
        wr(8'h0c, 32'h70);
        tchk(uhe_pkg::PID_IN, 4'h0, 5'h0, km, stl);
        tchk(uhe_pkg::PID_OUT, 4'h0, 5'h0, km, stl);
        tchk(uhe_pkg::PID_SETUP, 4'h0, 5'h01, km, ack);
        rchk(8'h0c, 32'h30);
        wr(8'h08, 32'h01);
        tchk(uhe_pkg::PID_IN, 4'h1, 5'h0, km, nak);
        chk(irq, 1'b0);
        wr(8'h10, 32'h6a);
        rchk(8'h10, 32'h6a);
        tchk(uhe_pkg::PID_IN, 4'h1, 5'h0, bm, {1'b1, uhe_pkg::RESP_DATA, 5'h0, 6'h2a});
        wr(8'h10, 32'hea);
        tchk(uhe_pkg::PID_IN, 4'h1, 5'h0, km, stl);
        // Frame timer: one frame is 200 cycles, second end-of-frame point 41 short of it
        i_uhe_host_model.event_pulse(5'h10);
        rchk(8'h00, 32'h02);
        wr(8'h00, 32'h0);
        rchk(8'h00, 32'h02);
        wr(8'h00, 32'h02);
        rchk(8'h00, 32'h0);
        i_uhe_host_model.event_pulse(5'h0c);
        rchk(8'h00, 32'h18);
        wr(8'h00, 32'h18);
        repeat (100) @(posedge aclk);
        rchk(8'h00, 32'h0);
        repeat (40) @(posedge aclk);
        rchk(8'h00, 32'h04);
        i_uhe_host_model.event_pulse(5'h10);
        rchk(8'h00, 32'h07);
        wr(8'h00, 32'h100);
        rchk(8'h00, 32'h107);
        chk(irq, 1'b1);
        wr(8'h00, 32'h1f);
        rchk(8'h00, 32'h0);
        chk(irq, 1'b0);
        rchk(8'h14, 32'h0, uhe_pkg::AXI_SLVERR);
        wr(8'h14, 32'hff);
        chk(br_q, uhe_pkg::AXI_SLVERR);
        por_n <= 1'b0;
        repeat (3) @(posedge aclk);
        por_n <= 1'b1;
        @(posedge aclk);
        rchk(8'h04, 32'h0);
        chk({reg_on, xcvr}, 2'b00);
        results();
    end

    initial begin
        repeat (5000) @(posedge aclk);
        error_cnt++;
        results();
    end
endmodule : tb
